// >>> src/dcc_pkg.sv
// package for the commissioning command block: register map, command bits, timing
// assumes a register port that presents 16-bit words with a write strobe
package dcc_pkg;
    localparam logic [15:0] DCC_LINE1_CMD_ADDR = 16'h9d3e;
    localparam logic [15:0] DCC_LINE2_CMD_ADDR = 16'h9d3f;
    localparam logic [15:0] DCC_LINE1_PCT_ADDR = 16'h7611;
    localparam logic [15:0] DCC_LINE2_PCT_ADDR = 16'h7612;
    localparam logic [15:0] DCC_CMD_RESET = 16'h0000;
    localparam int DCC_BIT_FACTORY = 11;
    localparam int DCC_BIT_FRESH = 12;
    localparam int DCC_BIT_SWAP = 13;
    localparam int DCC_BIT_ENROL = 14;
    localparam int DCC_BIT_CLEAR = 15;
    localparam int DCC_NUM_GEAR = 16;
    localparam logic [6:0] DCC_PCT_FULL = 7'h64;
    localparam int DCC_CLK_HZ = 40000000;
    localparam int DCC_STEP_US = 10;
    localparam int DCC_STEP_CYC = (DCC_CLK_HZ / 1000000) * DCC_STEP_US;
    localparam logic [15:0] DCC_LFSR_SEED = 16'hace1;
    typedef enum logic [2:0]
    {
        DCC_CMD_NONE,
        DCC_CMD_FACTORY,
        DCC_CMD_FRESH,
        DCC_CMD_SWAP,
        DCC_CMD_ENROL,
        DCC_CMD_CLEAR
    } dcc_cmd_t;
endpackage : dcc_pkg

// >>> src/dcc_line_if.sv
// interface between register front end and one line engine
// assumes a single clock domain
`timescale 1ns/1ps
`default_nettype none
interface dcc_line_if;
    import dcc_pkg::*;
    logic start;
    dcc_cmd_t cmd;
    logic busy;
    logic commissioned;
    logic [6:0] percent;
    modport ctrl (output start, output cmd, input busy, input commissioned, input percent);
    modport eng (input start, input cmd, output busy, output commissioned, output percent);
endinterface : dcc_line_if
`default_nettype wire

// >>> src/dcc_line_engine.sv
// one line engine: runs a commissioning command over sixteen gear slots
// assumes the fault map and gear presence come from the line's own receiver
`timescale 1ns/1ps
`default_nettype none
module dcc_line_engine
    import dcc_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    dcc_line_if.eng lif,
    input wire logic [15:0] i_unaddressed,
    input wire logic [15:0] i_fault_map,
    output logic o_cmd_valid,
    output dcc_cmd_t o_cmd,
    output logic [4:0] o_short_addr,
    output logic [15:0] o_addr_map
);
    typedef enum {DCC_IDLE, DCC_RUN} dcc_state_t;
    dcc_state_t state;
    dcc_cmd_t cur;
    logic [15:0] used;
    logic [15:0] pool;
    logic [15:0] lfsr;
    logic [4:0] slot;
    logic [$clog2(DCC_STEP_CYC)-1:0] tick_cnt;
    logic tick;
    logic known;

    function automatic logic [4:0] dcc_pick(input logic [15:0] m, input logic [3:0] rot);
        logic [4:0] r;
        logic [3:0] k;
        r = 5'h00;
        for (int i = 15; i >= 0; i--)
        begin
            k = 4'(i) + rot;
            if (m[k])
                r = {1'b0, k} + 5'h01;
        end
        return r;
    endfunction : dcc_pick

    assign tick = (tick_cnt == ($clog2(DCC_STEP_CYC))'(DCC_STEP_CYC - 1));

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            tick_cnt <= '0;
        else if (state != DCC_RUN || tick)
            tick_cnt <= '0;
        else
            tick_cnt <= tick_cnt + 1'b1;
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            lfsr <= DCC_LFSR_SEED;
        else
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state <= DCC_IDLE;
            cur <= DCC_CMD_NONE;
            slot <= 5'h00;
            used <= 16'h0000;
            pool <= 16'h0000;
            known <= 1'b0;
            o_cmd_valid <= 1'b0;
            o_cmd <= DCC_CMD_NONE;
            o_short_addr <= 5'h00;
        end
        else
        begin
            o_cmd_valid <= 1'b0;
            case (state)
                DCC_IDLE:
                begin
                    if (lif.start)
                    begin
                        cur <= lif.cmd;
                        slot <= 5'h00;
                        state <= DCC_RUN;
                        o_cmd_valid <= 1'b1;
                        o_cmd <= lif.cmd;
                        o_short_addr <= 5'h00;
                        case (lif.cmd)
                            DCC_CMD_FACTORY, DCC_CMD_CLEAR:
                            begin
                                used <= 16'h0000; // see RULE_01 see RULE_11
                                known <= 1'b0;
                                state <= DCC_IDLE;
                            end
                            DCC_CMD_FRESH:
                                pool <= 16'hffff;
                            DCC_CMD_SWAP:
                                pool <= i_fault_map; // see RULE_06 see RULE_08
                            default:
                                pool <= ~used; // see RULE_09 see RULE_10
                        endcase
                    end
                end
                DCC_RUN:
                begin
                    if (tick)
                    begin
                        if (slot == 5'(DCC_NUM_GEAR))
                        begin
                            state <= DCC_IDLE;
                            known <= 1'b1; // see RULE_04
                        end
                        else
                        begin
                            slot <= slot + 5'h01;
                            if (i_unaddressed[slot[3:0]] && pool != 16'h0000)
                            begin
                                o_cmd_valid <= 1'b1;
                                o_cmd <= cur;
                                if (cur == DCC_CMD_ENROL)
                                    o_short_addr <= dcc_pick(pool, 4'h0); // see RULE_09
                                else
                                    o_short_addr <= dcc_pick(pool, lfsr[3:0]); // see RULE_02 see RULE_03 see RULE_06
                                pool <= pool & ~(16'h0001 << (dcc_pick(pool, (cur == DCC_CMD_ENROL) ? 4'h0 : lfsr[3:0]) - 5'h01));
                                used <= used | (16'h0001 << (dcc_pick(pool, (cur == DCC_CMD_ENROL) ? 4'h0 : lfsr[3:0]) - 5'h01));
                            end
                        end
                    end
                end
                default:
                    state <= DCC_IDLE;
            endcase
        end
    end

    assign lif.busy = (state == DCC_RUN);
    assign lif.commissioned = known;
    assign lif.percent = (state == DCC_RUN) ? 7'((32'(slot) * 32'(DCC_PCT_FULL)) / DCC_NUM_GEAR) :
                         (known ? DCC_PCT_FULL : 7'h00); // see RULE_18
    assign o_addr_map = used;

    AST_POOL_WITHIN_FAULTS: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // see RULE_06
        (state == DCC_IDLE && lif.start && lif.cmd == DCC_CMD_SWAP) |=> (pool == $past(i_fault_map)))
        else $error("swap pool differs from fault map");
    AST_ENROL_KEEPS: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // see RULE_10
        (state == DCC_RUN && cur == DCC_CMD_ENROL) |=> ((used & $past(used)) == $past(used)))
        else $error("enrolment dropped an existing address");
    AST_CLEAR_WIPES: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // see RULE_11
        (state == DCC_IDLE && lif.start && lif.cmd == DCC_CMD_CLEAR) |=> (used == 16'h0000 && !known))
        else $error("clear left addresses");
    AST_PCT_RANGE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // see RULE_18
        lif.percent <= DCC_PCT_FULL)
        else $error("percent above full");
endmodule : dcc_line_engine
`default_nettype wire

// >>> src/dcc_commission.sv
// top of the commissioning command block: two command words, edge detection, two line engines
// assumes a synchronous 16-bit register port from the field-bus map
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE_01: line 1 bit 11 rise sends factory reset
// RULE_02: line 1 bit 12 rise commissions, random addresses
// RULE_03: fresh commissioning addresses all unaddressed gear
// RULE_04: single-gear functions blocked until commissioned
// RULE_05: line 1 swap only with nonzero fault map
// RULE_06: swap reuses faulty addresses, chosen randomly
// RULE_07: software swaps one faulty gear at a time
// RULE_08: fault at address n is bit n-1
// RULE_09: bit 14 rise enrols at lowest free address
// RULE_10: enrolment keeps existing addresses unchanged
// RULE_11: line 1 bit 15 rise clears addresses
// RULE_12: line 2 word repeats the five commands
// RULE_13: line 2 bit 11 rise factory resets
// RULE_14: line 2 bit 12 rise commissions afresh
// RULE_15: line 2 swap only with nonzero fault map
// RULE_16: line 2 bit 14 rise enrols gear
// RULE_17: line 2 bit 15 rise clears addresses
// RULE_18: readable commission percent per line, 0 to 100
// RULE_19: only zero-to-one changes trigger commands
module dcc_commission
    import dcc_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_reg_wr,
    input wire logic [15:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    output logic [15:0] o_reg_rdata,
    input wire logic [15:0] i_line1_fault_map,
    input wire logic [15:0] i_line2_fault_map,
    input wire logic [15:0] i_line1_unaddressed,
    input wire logic [15:0] i_line2_unaddressed,
    output logic o_line1_cmd_valid,
    output dcc_cmd_t o_line1_cmd,
    output logic [4:0] o_line1_short_addr,
    output logic [15:0] o_line1_addr_map,
    output logic o_line1_single_ok,
    output logic o_line2_cmd_valid,
    output dcc_cmd_t o_line2_cmd,
    output logic [4:0] o_line2_short_addr,
    output logic [15:0] o_line2_addr_map,
    output logic o_line2_single_ok
);
    logic [15:0] cmd_word [2];
    logic [15:0] prev_word [2];
    logic [15:0] rise [2];
    logic [15:0] fault [2];
    dcc_line_if lif [2] ();

    default clocking dcc_cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rstn);

    function automatic dcc_cmd_t dcc_decode(input logic [15:0] r, input logic [15:0] f);
        dcc_cmd_t c;
        c = DCC_CMD_NONE;
        if (r[DCC_BIT_FACTORY])
            c = DCC_CMD_FACTORY;
        else if (r[DCC_BIT_FRESH])
            c = DCC_CMD_FRESH;
        else if (r[DCC_BIT_SWAP] && f != 16'h0000)
            c = DCC_CMD_SWAP;
        else if (r[DCC_BIT_ENROL])
            c = DCC_CMD_ENROL;
        else if (r[DCC_BIT_CLEAR])
            c = DCC_CMD_CLEAR;
        return c;
    endfunction : dcc_decode

    assign fault[0] = i_line1_fault_map;
    assign fault[1] = i_line2_fault_map;

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            cmd_word[0] <= DCC_CMD_RESET;
            cmd_word[1] <= DCC_CMD_RESET;
        end
        else if (i_reg_wr)
        begin
            if (i_reg_addr == DCC_LINE1_CMD_ADDR)
                cmd_word[0] <= i_reg_wdata;
            if (i_reg_addr == DCC_LINE2_CMD_ADDR)
                cmd_word[1] <= i_reg_wdata; // see RULE_12
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            prev_word[0] <= DCC_CMD_RESET;
            prev_word[1] <= DCC_CMD_RESET;
        end
        else
        begin
            // an edge seen while busy is held off until idle
            if (!lif[0].busy)
                prev_word[0] <= cmd_word[0]; // see RULE_19
            if (!lif[1].busy)
                prev_word[1] <= cmd_word[1]; // see RULE_19
        end
    end

    assign rise[0] = cmd_word[0] & ~prev_word[0];
    assign rise[1] = cmd_word[1] & ~prev_word[1];

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_line
            assign lif[g].cmd = dcc_decode(rise[g], fault[g]); // see RULE_05 see RULE_15
            assign lif[g].start = !lif[g].busy && (lif[g].cmd != DCC_CMD_NONE);
        end
    endgenerate

    // see RULE_01 see RULE_02 see RULE_03 see RULE_09 see RULE_11
    dcc_line_engine u_line1 (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .lif(lif[0]),
        .i_unaddressed(i_line1_unaddressed),
        .i_fault_map(i_line1_fault_map),
        .o_cmd_valid(o_line1_cmd_valid),
        .o_cmd(o_line1_cmd),
        .o_short_addr(o_line1_short_addr),
        .o_addr_map(o_line1_addr_map)
    );

    // see RULE_13 see RULE_14 see RULE_16 see RULE_17
    dcc_line_engine u_line2 (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .lif(lif[1]),
        .i_unaddressed(i_line2_unaddressed),
        .i_fault_map(i_line2_fault_map),
        .o_cmd_valid(o_line2_cmd_valid),
        .o_cmd(o_line2_cmd),
        .o_short_addr(o_line2_short_addr),
        .o_addr_map(o_line2_addr_map)
    );

    assign o_line1_single_ok = lif[0].commissioned && !lif[0].busy; // see RULE_04
    assign o_line2_single_ok = lif[1].commissioned && !lif[1].busy; // see RULE_04

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_reg_rdata <= 16'h0000;
        else
        begin
            case (i_reg_addr)
                DCC_LINE1_CMD_ADDR: o_reg_rdata <= cmd_word[0];
                DCC_LINE2_CMD_ADDR: o_reg_rdata <= cmd_word[1];
                DCC_LINE1_PCT_ADDR: o_reg_rdata <= {9'h000, lif[0].percent}; // see RULE_18
                DCC_LINE2_PCT_ADDR: o_reg_rdata <= {9'h000, lif[1].percent};
                default: o_reg_rdata <= 16'h0000;
            endcase
        end
    end

    AST_RISE_ONLY: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // see RULE_19
        lif[0].start |=> (prev_word[0] == $past(cmd_word[0])))
        else $error("line 1 edge not consumed at launch");

    AST_SWAP_NEEDS_FAULT1: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // see RULE_05
        (lif[0].start && lif[0].cmd == DCC_CMD_SWAP) |-> i_line1_fault_map != 16'h0000)
        else $error("line 1 swap with empty fault map");

    AST_SWAP_NEEDS_FAULT2: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // see RULE_15
        (lif[1].start && lif[1].cmd == DCC_CMD_SWAP) |-> i_line2_fault_map != 16'h0000)
        else $error("line 2 swap with empty fault map");

    AST_FACTORY1_OUT: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // see RULE_01
        (lif[0].start && lif[0].cmd == DCC_CMD_FACTORY) |=> (o_line1_cmd_valid && o_line1_cmd == DCC_CMD_FACTORY))
        else $error("line 1 factory reset not sent");

    AST_FACTORY2_OUT: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // see RULE_13
        (lif[1].start && lif[1].cmd == DCC_CMD_FACTORY) |=> (o_line2_cmd_valid && o_line2_cmd == DCC_CMD_FACTORY))
        else $error("line 2 factory reset not sent");

    AST_SINGLE_BLOCKED: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // see RULE_04
        (lif[0].start && lif[0].cmd == DCC_CMD_CLEAR) |=> !o_line1_single_ok)
        else $error("single gear access after clear");

    AST_RISE_ONLY2: assert property ( // see RULE_19
        lif[1].start
        |=> (prev_word[1] == $past(cmd_word[1])))
        else $error("line 2 edge not consumed at launch");

    AST_NO_EDGE1: assert property ( // see RULE_19
        (cmd_word[0] == prev_word[0])
        |-> !lif[0].start)
        else $error("line 1 launch without edge");

    AST_NO_EDGE2: assert property ( // see RULE_19
        (cmd_word[1] == prev_word[1])
        |-> !lif[1].start)
        else $error("line 2 launch without edge");

    AST_SWAP_EMPTY1: assert property ( // see RULE_05
        (rise[0] == (16'h0001 << DCC_BIT_SWAP) && i_line1_fault_map == 16'h0000)
        |-> !lif[0].start)
        else $error("line 1 swap not dropped");

    AST_SWAP_EMPTY2: assert property ( // see RULE_15
        (rise[1] == (16'h0001 << DCC_BIT_SWAP) && i_line2_fault_map == 16'h0000)
        |-> !lif[1].start)
        else $error("line 2 swap not dropped");

    AST_FRESH1_OUT: assert property ( // see RULE_02
        (lif[0].start && lif[0].cmd == DCC_CMD_FRESH)
        |=> (o_line1_cmd_valid && o_line1_cmd == DCC_CMD_FRESH && o_line1_short_addr == 5'h00))
        else $error("line 1 fresh not sent");

    AST_FRESH2_OUT: assert property ( // see RULE_14
        (lif[1].start && lif[1].cmd == DCC_CMD_FRESH)
        |=> (o_line2_cmd_valid && o_line2_cmd == DCC_CMD_FRESH && o_line2_short_addr == 5'h00))
        else $error("line 2 fresh not sent");

    AST_SWAP1_OUT: assert property ( // see RULE_05
        (lif[0].start && lif[0].cmd == DCC_CMD_SWAP)
        |=> (o_line1_cmd_valid && o_line1_cmd == DCC_CMD_SWAP))
        else $error("line 1 swap not sent");

    AST_SWAP2_OUT: assert property ( // see RULE_15
        (lif[1].start && lif[1].cmd == DCC_CMD_SWAP)
        |=> (o_line2_cmd_valid && o_line2_cmd == DCC_CMD_SWAP))
        else $error("line 2 swap not sent");

    AST_ENROL1_OUT: assert property ( // see RULE_09
        (lif[0].start && lif[0].cmd == DCC_CMD_ENROL)
        |=> (o_line1_cmd_valid && o_line1_cmd == DCC_CMD_ENROL))
        else $error("line 1 enrol not sent");

    AST_ENROL2_OUT: assert property ( // see RULE_16
        (lif[1].start && lif[1].cmd == DCC_CMD_ENROL)
        |=> (o_line2_cmd_valid && o_line2_cmd == DCC_CMD_ENROL))
        else $error("line 2 enrol not sent");

    AST_CLEAR1_OUT: assert property ( // see RULE_11
        (lif[0].start && lif[0].cmd == DCC_CMD_CLEAR)
        |=> (o_line1_cmd_valid && o_line1_cmd == DCC_CMD_CLEAR && o_line1_addr_map == 16'h0000))
        else $error("line 1 clear not sent");

    AST_CLEAR2_OUT: assert property ( // see RULE_17
        (lif[1].start && lif[1].cmd == DCC_CMD_CLEAR)
        |=> (o_line2_cmd_valid && o_line2_cmd == DCC_CMD_CLEAR && o_line2_addr_map == 16'h0000))
        else $error("line 2 clear not sent");

    AST_FACTORY1_WIPES: assert property ( // see RULE_01
        (lif[0].start && lif[0].cmd == DCC_CMD_FACTORY)
        |=> (o_line1_addr_map == 16'h0000 && !o_line1_single_ok))
        else $error("line 1 map kept after reset");

    AST_FACTORY2_WIPES: assert property ( // see RULE_13
        (lif[1].start && lif[1].cmd == DCC_CMD_FACTORY)
        |=> (o_line2_addr_map == 16'h0000 && !o_line2_single_ok))
        else $error("line 2 map kept after reset");

    AST_SINGLE_BLOCKED2: assert property ( // see RULE_04
        (lif[1].start && lif[1].cmd == DCC_CMD_CLEAR)
        |=> !o_line2_single_ok)
        else $error("line 2 single gear access after clear");

    AST_FACTORY1_FIRST: assert property ( // see RULE_01
        (rise[0][DCC_BIT_FACTORY] && !lif[0].busy)
        |-> (lif[0].start && lif[0].cmd == DCC_CMD_FACTORY))
        else $error("line 1 factory edge not launched");

    AST_FACTORY2_FIRST: assert property ( // see RULE_13
        (rise[1][DCC_BIT_FACTORY] && !lif[1].busy)
        |-> (lif[1].start && lif[1].cmd == DCC_CMD_FACTORY))
        else $error("line 2 factory edge not launched");

    AST_WRITE1_LANDS: assert property ( // see RULE_01
        (i_reg_wr && i_reg_addr == DCC_LINE1_CMD_ADDR)
        |=> (cmd_word[0] == $past(i_reg_wdata)))
        else $error("line 1 word write lost");

    AST_WRITE2_LANDS: assert property ( // see RULE_12
        (i_reg_wr && i_reg_addr == DCC_LINE2_CMD_ADDR)
        |=> (cmd_word[1] == $past(i_reg_wdata)))
        else $error("line 2 word write lost");

    AST_WRITE2_APART: assert property ( // see RULE_12
        (i_reg_wr && i_reg_addr == DCC_LINE1_CMD_ADDR)
        |=> $stable(cmd_word[1]))
        else $error("line 1 write touched line 2 word");

    AST_PCT1_READ: assert property ( // see RULE_18
        (i_reg_addr == DCC_LINE1_PCT_ADDR)
        |=> (o_reg_rdata == {9'h000, $past(lif[0].percent)}))
        else $error("line 1 percent read wrong");

    AST_PCT2_READ: assert property ( // see RULE_18
        (i_reg_addr == DCC_LINE2_PCT_ADDR)
        |=> (o_reg_rdata == {9'h000, $past(lif[1].percent)}))
        else $error("line 2 percent read wrong");
endmodule : dcc_commission
`default_nettype wire

// >>> verification/dcc_gear_model.sv
// ballast model for one line: tracks which gear slots hold a short address
// assumes the command outputs of that line and a present-gear mask from the bench
`timescale 1ns/1ps
`default_nettype none
module dcc_gear_model
    import dcc_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic [15:0] i_present,
    input wire logic i_cmd_valid,
    input wire dcc_cmd_t i_cmd,
    input wire logic [4:0] i_short_addr,
    output logic [15:0] o_unaddressed
);
    logic [15:0] has_addr;
    assign o_unaddressed = i_present & ~has_addr;
    // lowest waiting slot takes each address; reset and clear drop all addresses
    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            has_addr <= 16'h0000;
        else if (i_cmd_valid && (i_cmd == DCC_CMD_FACTORY || i_cmd == DCC_CMD_CLEAR))
            has_addr <= 16'h0000;
        else if (i_cmd_valid && i_short_addr != 5'h00)
            has_addr <= has_addr | (o_unaddressed & (~o_unaddressed + 16'h0001));
    end
endmodule : dcc_gear_model
`default_nettype wire

// >>> verification/tb_top.sv
// testbench for the commissioning command block, one ballast model per line
// assumes the design package and a 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dcc_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic wr = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] fault1 = 16'h0000;
    logic [15:0] fault2 = 16'h0000;
    logic [15:0] pres1 = 16'h000f;
    logic [15:0] pres2 = 16'h0003;
    logic [15:0] rdata, un1, un2, map1, map2;
    logic v1, v2, ok1, ok2;
    dcc_cmd_t c1, c2, first_cmd;
    logic [4:0] a1, a2;
    logic [4:0] q_addr[$];
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    int n_pulse, n_other;

    dcc_commission dcc_commission_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_reg_wr(wr),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_line1_fault_map(fault1),
        .i_line2_fault_map(fault2), .i_line1_unaddressed(un1), .i_line2_unaddressed(un2),
        .o_line1_cmd_valid(v1), .o_line1_cmd(c1), .o_line1_short_addr(a1), .o_line1_addr_map(map1),
        .o_line1_single_ok(ok1), .o_line2_cmd_valid(v2), .o_line2_cmd(c2), .o_line2_short_addr(a2),
        .o_line2_addr_map(map2), .o_line2_single_ok(ok2));
    dcc_gear_model dcc_gear_model_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_present(pres1),
        .i_cmd_valid(v1), .i_cmd(c1), .i_short_addr(a1), .o_unaddressed(un1));
    dcc_gear_model dcc_gear_model_i2 (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_present(pres2),
        .i_cmd_valid(v2), .i_cmd(c2), .i_short_addr(a2), .o_unaddressed(un2));

    always #12.5 i_sys_clk = ~i_sys_clk;

    always @(posedge i_sys_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 95000)
        begin
            err_total = err_total + 1;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk16

    task automatic wr_word(input logic [15:0] a, input logic [15:0] d);
        @(negedge i_sys_clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge i_sys_clk);
        wr = 1'b0;
    endtask : wr_word

    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        @(negedge i_sys_clk);
        addr = a;
        @(negedge i_sys_clk);
        chk16(rdata, exp);
    endtask : rd_chk

    // watch one line for n cycles, note the first command and every assigned address
    task automatic collect(input int ln, input int n);
        q_addr.delete();
        n_pulse = 0;
        n_other = 0;
        first_cmd = DCC_CMD_NONE;
        repeat (n)
        begin
            @(negedge i_sys_clk);
            if (((ln == 1) ? v1 : v2) === 1'b1)
            begin
                if (n_pulse == 0)
                    first_cmd = (ln == 1) ? c1 : c2;
                n_pulse = n_pulse + 1;
                if (((ln == 1) ? a1 : a2) != 5'h00)
                    q_addr.push_back((ln == 1) ? a1 : a2);
            end
            if (((ln == 1) ? v2 : v1) === 1'b1)
                n_other = n_other + 1;
        end
    endtask : collect

    task automatic fire(input int ln, input int b, input int n);
        wr_word((ln == 1) ? DCC_LINE1_CMD_ADDR : DCC_LINE2_CMD_ADDR, 16'h0000);
        wr_word((ln == 1) ? DCC_LINE1_CMD_ADDR : DCC_LINE2_CMD_ADDR, 16'h0001 << b);
        collect(ln, n);
    endtask : fire

    task automatic t_reset();
        chk16({15'h0000, ok1}, 16'h0000);
        rd_chk(DCC_LINE1_PCT_ADDR, 16'h0000);
        rd_chk(16'h0000, 16'h0000);
    endtask : t_reset

    task automatic t_fresh();
        fire(1, DCC_BIT_FRESH, 7000);
        chk16(16'(first_cmd), 16'(DCC_CMD_FRESH));
        chk16(16'(q_addr.size()), 16'h0004);
        chk16(un1, 16'h0000);
        chk16(16'($countones(map1)), 16'h0004);
        chk16({15'h0000, ok1}, 16'h0001);
        chk16(16'(n_other), 16'h0000);
        rd_chk(DCC_LINE1_PCT_ADDR, {9'h000, DCC_PCT_FULL});
        wr_word(DCC_LINE1_CMD_ADDR, 16'h1000);
        collect(1, 50);
        chk16(16'(n_pulse), 16'h0000);
        rd_chk(DCC_LINE1_CMD_ADDR, 16'h1000);
    endtask : t_fresh

    task automatic t_clear_enrol();
        fire(1, DCC_BIT_CLEAR, 50);
        chk16(16'(first_cmd), 16'(DCC_CMD_CLEAR));
        chk16(map1, 16'h0000);
        chk16({15'h0000, ok1}, 16'h0000);
        fire(1, DCC_BIT_ENROL, 7000);
        chk16(16'(first_cmd), 16'(DCC_CMD_ENROL));
        chk16(16'(q_addr.size()), 16'h0004);
        foreach (q_addr[k])
            chk16(16'(q_addr[k]), 16'(k + 1));
        pres1 = 16'h010f;
        fire(1, DCC_BIT_ENROL, 7000);
        chk16(16'(q_addr.size()), 16'h0001);
        chk16(16'(q_addr[0]), 16'h0005);
        chk16(map1, 16'h001f);
    endtask : t_clear_enrol

    task automatic t_swap();
        fire(1, DCC_BIT_SWAP, 50);
        chk16(16'(n_pulse), 16'h0000);
        fault1 = 16'h0002;
        pres1 = 16'h030d;
        fire(1, DCC_BIT_SWAP, 7000); // one faulty unit per run
        chk16(16'(first_cmd), 16'(DCC_CMD_SWAP));
        chk16(16'(q_addr.size()), 16'h0001);
        chk16(16'(q_addr[0]), 16'h0002);
        chk16(map1, 16'h001f);
        fire(1, DCC_BIT_FACTORY, 50);
        chk16(16'(first_cmd), 16'(DCC_CMD_FACTORY));
        chk16(map1, 16'h0000);
        chk16({15'h0000, ok1}, 16'h0000);
    endtask : t_swap

    task automatic t_line2();
        dcc_cmd_t exp_cmd[5] = '{DCC_CMD_FACTORY, DCC_CMD_FRESH, DCC_CMD_SWAP, DCC_CMD_ENROL, DCC_CMD_CLEAR};
        fire(2, DCC_BIT_SWAP, 50);
        chk16(16'(n_pulse), 16'h0000);
        fault2 = 16'h0001;
        for (int k = 0; k < 5; k++)
        begin
            fire(2, DCC_BIT_FACTORY + k, 7000);
            chk16(16'(first_cmd), 16'(exp_cmd[k]));
            chk16(16'(n_other), 16'h0000);
            if (k == 1)
            begin
                chk16(16'(q_addr.size()), 16'h0002);
                chk16({15'h0000, ok2}, 16'h0001);
                rd_chk(DCC_LINE2_PCT_ADDR, {9'h000, DCC_PCT_FULL});
            end
        end
        chk16(map2, 16'h0000);
        chk16({15'h0000, ok2}, 16'h0000);
    endtask : t_line2

    initial
    begin
        repeat (10) @(negedge i_sys_clk);
        i_rstn = 1'b1;
        t_reset();
        t_fresh();
        t_clear_enrol();
        t_swap();
        t_line2();
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
